// ===== trt_consts.vh
// constants for the triple reload/capture timer
// assumes a 40 MHz system clock and a 32-bit AXI4-Lite bus
`ifndef TRT_CONSTS_VH
`define TRT_CONSTS_VH
// register indices; byte address is four times the index
`define TRT_IDX_MODE1   16'hd118
`define TRT_IDX_MODE2   16'hd119
`define TRT_IDX_CAP1    16'hd11a
`define TRT_IDX_CAP2    16'hd11b
`define TRT_IDX_LOAD1   16'hd11c
`define TRT_IDX_LOAD2   16'hd11d
`define TRT_IDX_LOAD3   16'hd11e
`define TRT_IDX_CS      16'hd11f
`define TRT_IDX_ISTAT   16'hd120
`define TRT_IDX_IMASK   16'hd121
// reset values
`define TRT_RST_MODE    8'h00
`define TRT_RST_CAP     8'hff
`define TRT_RST_LOAD    8'hff
`define TRT_RST_CS      8'h03
`define TRT_RST_IRQ     5'h00
// mode register one fields
`define TRT_M1_CLEAR_ON_CAPTURE_TWO     7
`define TRT_M1_ACBR     6
`define TRT_M1_RLD      5
`define TRT_M1_RELOAD_TRIGGER_SELECT     4
`define TRT_M1_CS2_HI   3
`define TRT_M1_CS2_LO   2
`define TRT_M1_C1MODE   1
`define TRT_M1_CAPSEL   0
// mode register two fields
`define TRT_M2_LAT      7
`define TRT_M2_CS1_HI   6
`define TRT_M2_CS1_LO   5
`define TRT_M2_CS3_HI   4
`define TRT_M2_CS3_LO   3
`define TRT_M2_CPSLM    2
`define TRT_M2_CAPTURE_FLAG     1
`define TRT_M2_SLW      0
// control/status read-as-one bits
`define TRT_CS_FIXED    8'h03
// interrupt status bit positions
`define TRT_IS_UF1      0
`define TRT_IS_UF2      1
`define TRT_IS_UF3      2
`define TRT_IS_CAP1     3
`define TRT_IS_CAP2     4
// prescaler widths (divide by two to the n)
`define TRT_PS_W        12
`define TRT_DIV4        2
`define TRT_DIV64       6
`define TRT_DIV128      7
`define TRT_DIV256      8
`define TRT_DIV512      9
`define TRT_DIV1024     10
`define TRT_DIV2048     11
`define TRT_DIV4096     12
// bus answers
`define TRT_RESP_OK     2'b00
`define TRT_RESP_ERR    2'b10
`endif

// ===== trt_timer.v
// triple 8-bit down-counting reload/capture timer with AXI4-Lite registers
// assumes pulse and pin inputs already synchronous to clk_sys
`timescale 1ns/1ps
`default_nettype none
`include "trt_consts.vh"

// Summary of operation
// - three 8-bit down-counters; one and two capture, three only reloads
// - mode register one clears to zero on reset
// - low power keeps registers but clears capture and slow-tracking flags
// - clear_on_capture_two set clears counter two on its capture
// - accel_brake_select picks acceleration or braking completion detection
// - reload_enable_two makes counter two reload, else no reload
// - reload_trigger_select picks pulse edge or underflow, only when enabled
// - counter two clock: counter one underflow, /256, /128, /64
// - counter_one_mode picks reload or capture timer; capture never reloads
// - counter one clears right after each capture
// - capture_source_select_lo picks pulse or pin for counter one capture
// - select_lo also applies with select_hi set, the two jointly
// - counter two captures on counter three underflow or selected edge
// - counter three clock: divided pulse edge, /4096, /2048, /1024
module trt_timer (
  // clock and reset
  input  wire        clk_sys,
  input  wire        rst_n,
  // axi4-lite write address
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // timer inputs
  input  wire        capstan_pulse,
  input  wire        ext_capture_pin,
  input  wire        divided_control_pulse,
  input  wire        low_power,
  // status outputs
  output reg         accel_brake_select,
  output reg         irq
);

////////////////////////////////////////////////////////////////////////
// decode helpers

// maps a byte address to a local register number, 4'hf when unmapped
function [3:0] reg_sel;
  input [31:0] addr;
  begin
    if (addr[1:0] != 2'b00 || addr[31:18] != 14'h0)
      reg_sel = 4'hf;
    else
      case (addr[17:2])
        `TRT_IDX_MODE1: reg_sel = 4'h0;
        `TRT_IDX_MODE2: reg_sel = 4'h1;
        `TRT_IDX_CAP1:  reg_sel = 4'h2;
        `TRT_IDX_CAP2:  reg_sel = 4'h3;
        `TRT_IDX_LOAD1: reg_sel = 4'h4;
        `TRT_IDX_LOAD2: reg_sel = 4'h5;
        `TRT_IDX_LOAD3: reg_sel = 4'h6;
        `TRT_IDX_CS:    reg_sel = 4'h7;
        `TRT_IDX_ISTAT: reg_sel = 4'h8;
        `TRT_IDX_IMASK: reg_sel = 4'h9;
        default:        reg_sel = 4'hf;
      endcase
  end
endfunction

// one-cycle tick each time the low n prescaler bits wrap
function ps_tick;
  input [11:0] ps;
  input integer n;
  integer i;
  begin
    ps_tick = 1'b1;
    for (i = 0; i < 12; i = i + 1)
      if (i < n && !ps[i])
        ps_tick = 1'b0;
  end
endfunction

////////////////////////////////////////////////////////////////////////
// registers

reg  [7:0]  mode_reg_one;
reg  [7:0]  mode_reg_two;
reg  [7:0]  capture_value_one;
reg  [7:0]  capture_value_two;
reg  [7:0]  reload_value_one;
reg  [7:0]  reload_value_two;
reg  [7:0]  reload_value_three;
reg  [7:0]  irq_control_status;
reg  [4:0]  irq_status;
reg  [4:0]  irq_mask;
reg  [7:0]  cnt_one;
reg  [7:0]  cnt_two;
reg  [7:0]  cnt_three;
reg  [11:0] prescaler_s;
reg         pulse_q;
reg         pin_q;
reg         dvc_q;
reg  [31:0] aw_addr;
reg  [31:0] w_data;
reg  [3:0]  w_strb;
reg         aw_got;
reg         w_got;

////////////////////////////////////////////////////////////////////////
// edges and clock selection

wire pulse_rise = capstan_pulse & ~pulse_q;
// pin edge is taken as the falling edge (active-low request pin)
wire pin_fall   = ~ext_capture_pin & pin_q;
wire dvc_rise   = divided_control_pulse & ~dvc_q;

reg  tick_one;
reg  tick_two;
reg  tick_three;
wire uf_one   = tick_one & (cnt_one == 8'h00);
wire uf_two   = tick_two & (cnt_two == 8'h00);
wire uf_three = tick_three & (cnt_three == 8'h00);

always @*
begin
  case (mode_reg_two[`TRT_M2_CS1_HI:`TRT_M2_CS1_LO])
    2'b00:   tick_one = pulse_rise;
    2'b01:   tick_one = ps_tick(prescaler_s, `TRT_DIV4);
    2'b10:   tick_one = ps_tick(prescaler_s, `TRT_DIV256);
    default: tick_one = ps_tick(prescaler_s, `TRT_DIV512);
  endcase
  case (mode_reg_one[`TRT_M1_CS2_HI:`TRT_M1_CS2_LO])
    2'b00:   tick_two = uf_one;
    2'b01:   tick_two = ps_tick(prescaler_s, `TRT_DIV256);
    2'b10:   tick_two = ps_tick(prescaler_s, `TRT_DIV128);
    default: tick_two = ps_tick(prescaler_s, `TRT_DIV64);
  endcase
  case (mode_reg_two[`TRT_M2_CS3_HI:`TRT_M2_CS3_LO])
    2'b00:   tick_three = dvc_rise;
    2'b01:   tick_three = ps_tick(prescaler_s, `TRT_DIV4096);
    2'b10:   tick_three = ps_tick(prescaler_s, `TRT_DIV2048);
    default: tick_three = ps_tick(prescaler_s, `TRT_DIV1024);
  endcase
end

////////////////////////////////////////////////////////////////////////
// capture and reload triggers

wire sel_edge = mode_reg_one[`TRT_M1_CAPSEL] ? pin_fall : pulse_rise;
wire cap_one  = mode_reg_one[`TRT_M1_C1MODE] & sel_edge;
wire cap_two  = mode_reg_two[`TRT_M2_LAT] ? sel_edge : uf_three;

wire rld_two  = mode_reg_one[`TRT_M1_RLD] &
                (mode_reg_one[`TRT_M1_RELOAD_TRIGGER_SELECT] ? uf_two : pulse_rise);

////////////////////////////////////////////////////////////////////////
// counters

always @(posedge clk_sys)
begin
  if (!rst_n)
  begin
    prescaler_s <= 12'h000;
    pulse_q     <= 1'b0;
    pin_q       <= 1'b1;
    dvc_q       <= 1'b0;
    cnt_one     <= 8'h00;
    cnt_two     <= 8'h00;
    cnt_three   <= 8'h00;
    capture_value_one <= `TRT_RST_CAP;
    capture_value_two <= `TRT_RST_CAP;
  end
  else
  begin
    prescaler_s <= prescaler_s + 12'h001;
    pulse_q     <= capstan_pulse;
    pin_q       <= ext_capture_pin;
    dvc_q       <= divided_control_pulse;
    if (cap_one)
    begin
      capture_value_one <= cnt_one;
      cnt_one <= 8'h00;
    end
    else if (uf_one && !mode_reg_one[`TRT_M1_C1MODE])
      cnt_one <= reload_value_one;
    else if (tick_one)
      // capture mode wraps freely: no reload
      cnt_one <= cnt_one - 8'h01;
    // counter two: capture clear beats reload beats count
    if (cap_two)
      capture_value_two <= cnt_two;
    if (cap_two && mode_reg_one[`TRT_M1_CLEAR_ON_CAPTURE_TWO])
      cnt_two <= 8'h00;
    else if (rld_two)
      cnt_two <= reload_value_two;
    else if (tick_two)
      cnt_two <= cnt_two - 8'h01;
    // counter three always reloads on underflow
    if (uf_three)
      cnt_three <= reload_value_three;
    else if (tick_three)
      cnt_three <= cnt_three - 8'h01;
  end
end

////////////////////////////////////////////////////////////////////////
// register bus

wire        aw_hs   = s_axi_awvalid & s_axi_awready;
wire        w_hs    = s_axi_wvalid & s_axi_wready;
wire        ar_hs   = s_axi_arvalid & s_axi_arready;
wire        do_wr   = aw_got & w_got & ~s_axi_bvalid;
wire [3:0]  wr_sel  = reg_sel(aw_addr);
wire [3:0]  rd_sel  = reg_sel(s_axi_araddr);
wire        wr_lane = do_wr & w_strb[0];
wire [7:0]  wbyte   = w_data[7:0];
wire        rd_stat = ar_hs & (rd_sel == 4'h8);

always @(posedge clk_sys)
begin
  if (!rst_n)
  begin
    s_axi_awready <= 1'b1;
    s_axi_wready  <= 1'b1;
    s_axi_arready <= 1'b1;
    s_axi_bvalid  <= 1'b0;
    s_axi_bresp   <= `TRT_RESP_OK;
    s_axi_rvalid  <= 1'b0;
    s_axi_rresp   <= `TRT_RESP_OK;
    s_axi_rdata   <= 32'h00000000;
    aw_addr <= 32'h00000000;
    w_data  <= 32'h00000000;
    w_strb  <= 4'h0;
    aw_got  <= 1'b0;
    w_got   <= 1'b0;
  end
  else
  begin
    if (aw_hs)
    begin
      aw_addr       <= s_axi_awaddr;
      aw_got        <= 1'b1;
      s_axi_awready <= 1'b0;
    end
    if (w_hs)
    begin
      w_data       <= s_axi_wdata;
      w_strb       <= s_axi_wstrb;
      w_got        <= 1'b1;
      s_axi_wready <= 1'b0;
    end
    if (do_wr)
    begin
      aw_got       <= 1'b0;
      w_got        <= 1'b0;
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wr_sel == 4'hf) ? `TRT_RESP_ERR : `TRT_RESP_OK;
    end
    else if (s_axi_bvalid && s_axi_bready)
    begin
      s_axi_bvalid  <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
    end
    if (ar_hs)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= (rd_sel == 4'hf) ? `TRT_RESP_ERR : `TRT_RESP_OK;
      case (rd_sel)
        4'h0:    s_axi_rdata <= {24'h000000, mode_reg_one};
        4'h1:    s_axi_rdata <= {24'h000000, mode_reg_two};
        4'h2:    s_axi_rdata <= {24'h000000, capture_value_one};
        4'h3:    s_axi_rdata <= {24'h000000, capture_value_two};
        4'h7:    s_axi_rdata <= {24'h000000, irq_control_status};
        4'h8:    s_axi_rdata <= {27'h0, irq_status};
        4'h9:    s_axi_rdata <= {27'h0, irq_mask};
        // load registers are write-only and read as zero
        default: s_axi_rdata <= 32'h00000000;
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
end

////////////////////////////////////////////////////////////////////////
// software registers and flags

wire       wr_m2   = wr_lane & (wr_sel == 4'h1);
// flags clear by writing zero or in low power; hardware set beats a write clear
wire       capture_flag_set = cap_two & ~mode_reg_two[`TRT_M2_CPSLM];
wire       capture_flag_clr = wr_m2 & ~wbyte[`TRT_M2_CAPTURE_FLAG];
wire       slw_clr  = wr_m2 & ~wbyte[`TRT_M2_SLW];
wire [4:0] irq_ev  = {cap_two, cap_one, uf_three, uf_two, uf_one};
reg  [4:0] next_irq_status;
reg        next_capture_flag;
reg        next_slw;

always @*
begin
  next_irq_status = (rd_stat ? 5'h00 : irq_status) | irq_ev;
  next_capture_flag = capture_flag_set | (mode_reg_two[`TRT_M2_CAPTURE_FLAG] & ~capture_flag_clr);
  next_slw  = mode_reg_two[`TRT_M2_SLW] & ~slw_clr;
  if (low_power)
  begin
    next_capture_flag = 1'b0;
    next_slw  = 1'b0;
  end
end

always @(posedge clk_sys)
begin
  if (!rst_n)
  begin
    mode_reg_one       <= `TRT_RST_MODE;
    mode_reg_two       <= `TRT_RST_MODE;
    reload_value_one   <= `TRT_RST_LOAD;
    reload_value_two   <= `TRT_RST_LOAD;
    reload_value_three <= `TRT_RST_LOAD;
    irq_control_status <= `TRT_RST_CS;
    irq_status         <= `TRT_RST_IRQ;
    irq_mask           <= `TRT_RST_IRQ;
    accel_brake_select <= 1'b0;
    irq                <= 1'b0;
  end
  else
  begin
    if (wr_lane)
      case (wr_sel)
        4'h0: mode_reg_one <= wbyte;
        4'h4: reload_value_one <= wbyte;
        4'h5: reload_value_two <= wbyte;
        4'h6: reload_value_three <= wbyte;
        4'h7: irq_control_status <= wbyte | `TRT_CS_FIXED;
        4'h9: irq_mask <= wbyte[4:0];
        default: ;
      endcase
    if (wr_m2)
      mode_reg_two[7:2] <= wbyte[7:2];
    mode_reg_two[`TRT_M2_CAPTURE_FLAG] <= next_capture_flag;
    mode_reg_two[`TRT_M2_SLW]  <= next_slw;
    irq_status <= next_irq_status;
    accel_brake_select <= mode_reg_one[`TRT_M1_ACBR];
    irq <= |(next_irq_status & irq_mask);
  end
end

endmodule // trt_timer
`default_nettype wire

// ===== trt_asserts.sv
// checker on the timer's bus and status ports
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module trt_asserts (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        rst_n,
  // bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // status
  input wire logic        accel_brake_select,
  input wire logic        irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////
  property p_reset_idle;
    $rose(rst_n) |-> !s_axi_bvalid && !s_axi_rvalid && !irq && !accel_brake_select && s_axi_awready;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("outputs busy after reset");
  // copy only moves after a register write
  property p_abs_source;
    $changed(accel_brake_select) && $past(rst_n) |-> $past(s_axi_bvalid);
  endproperty
  a_abs_source: assert property (p_abs_source) else $error("select moved without write");
  property p_aw_held;
    !s_axi_awready && !(s_axi_bvalid && s_axi_bready) |=> !s_axi_awready;
  endproperty
  a_aw_held: assert property (p_aw_held) else $error("address taken mid write");
  property p_write_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("write not answered");
  property p_b_release;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready;
  endproperty
  a_b_release: assert property (p_b_release) else $error("response not released");
  property p_read_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered");
  property p_read_stands;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_read_stands: assert property (p_read_stands) else $error("read data moved");
  // registers are one byte wide
  property p_rdata_byte;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
  endproperty
  a_rdata_byte: assert property (p_rdata_byte) else $error("upper read bits set");
endmodule // trt_asserts
bind trt_timer trt_asserts trt_asserts_inst (.clk_sys, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .accel_brake_select, .irq);
`default_nettype wire

// ===== trt_src.sv
// capstan pulse and capture pin source for the timer
// assumes the bench calls its tasks from one process
`timescale 1ns/1ps
`default_nettype none
module trt_src (
  // clock
  input wire logic clk_sys,
  // event lines
  output var logic capstan_pulse,
  output var logic ext_capture_pin,
  output var logic divided_control_pulse
);
  initial
  begin
    capstan_pulse = 1'b0;
    ext_capture_pin = 1'b1;
    divided_control_pulse = 1'b0;
  end
  task automatic pulses(input int k);
    repeat (k)
    begin
      @(posedge clk_sys);
      capstan_pulse <= 1'b1;
      repeat (2) @(posedge clk_sys);
      capstan_pulse <= 1'b0;
      @(posedge clk_sys);
    end
  endtask
  task automatic pin_edge();
    @(posedge clk_sys);
    ext_capture_pin <= 1'b0;
    repeat (3) @(posedge clk_sys);
    ext_capture_pin <= 1'b1;
    repeat (3) @(posedge clk_sys);
  endtask
  // one rising edge per loop on the divided control line
  task automatic dvc_pulses(input int k);
    repeat (k)
    begin
      @(posedge clk_sys);
      divided_control_pulse <= 1'b1;
      @(posedge clk_sys);
      divided_control_pulse <= 1'b0;
    end
  endtask
endmodule // trt_src
`default_nettype wire

// ===== tb.sv
// self-checking bench for the triple timer
// assumes trt_src drives the event inputs
`timescale 1ns/1ps
`default_nettype none
`include "trt_consts.vh"
module tb;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic        low_power = 1'b0;
  wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic   accel_brake_select, irq, capstan_pulse, ext_capture_pin, divided_control_pulse;
  wire logic [1:0]  s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  int          bad_count = 0, total_checks = 0, k;
  logic [7:0]  d, vals [4];
  logic [1:0]  r;
  trt_timer trt_timer_inst (.clk_sys, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .capstan_pulse,
    .ext_capture_pin, .divided_control_pulse, .low_power, .accel_brake_select, .irq);
  trt_src trt_src_inst (.clk_sys, .capstan_pulse, .ext_capture_pin, .divided_control_pulse);
  always #12.5 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] ba(input logic [15:0] i);
    return {14'h0, i, 2'b00};
  endfunction
  // counter one wraps from zero, then counts down
  function automatic logic [7:0] cap_exp(input int n);
    return 8'(256 - n);
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus_write(input logic [31:0] a, input logic [7:0] v, output logic [1:0] rs);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic bus_read(input logic [31:0] a, output logic [7:0] v, output logic [1:0] rs);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    // late ready: read data must stand while the master stalls
    @(posedge clk_sys);
    s_axi_rready <= 1'b1;
    do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata[7:0];
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic expect_reg(input logic [15:0] i, input logic [7:0] e);
    logic [7:0] v;
    logic [1:0] rs;
    bus_read(ba(i), v, rs);
    check(v, e);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    conclude();
  end
  initial
  begin
    void'($urandom(32'h15e2));
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    expect_reg(`TRT_IDX_MODE1, `TRT_RST_MODE);
    expect_reg(`TRT_IDX_CAP1, `TRT_RST_CAP);
    expect_reg(`TRT_IDX_CS, `TRT_RST_CS);
    bus_write(ba(`TRT_IDX_CAP2), 8'h5a, r);
    expect_reg(`TRT_IDX_CAP2, `TRT_RST_CAP);
    bus_write(ba(`TRT_IDX_LOAD1), 8'h5a, r);
    check({6'h0, r}, {6'h0, `TRT_RESP_OK});
    bus_read(ba(16'hd117), d, r);
    check({6'h0, r}, {6'h0, `TRT_RESP_ERR});
    // corner values first, then random ones
    vals = '{8'hff, 8'h40, 8'($urandom), 8'($urandom)};
    foreach (vals[i])
    begin
      bus_write(ba(`TRT_IDX_MODE1), vals[i], r);
      @(posedge clk_sys);
      check({7'h0, accel_brake_select}, {7'h0, vals[i][6]});
      expect_reg(`TRT_IDX_MODE1, vals[i]);
    end
    // counter one captures on the pin; counter two clears on capture
    bus_write(ba(`TRT_IDX_MODE1), 8'h83, r);
    bus_write(ba(`TRT_IDX_MODE2), 8'h80, r);
    for (int n = 0; n < 2; n++)
    begin
      k = 1 + $urandom % 40;
      trt_src_inst.pulses(k);
      trt_src_inst.pin_edge();
      expect_reg(`TRT_IDX_CAP1, cap_exp(k));
    end
    expect_reg(`TRT_IDX_CAP2, 8'hff);
    check({7'h0, irq}, 8'h0);
    bus_write(ba(`TRT_IDX_IMASK), 8'h08, r);
    @(posedge clk_sys);
    check({7'h0, irq}, 8'h1);
    expect_reg(`TRT_IDX_MODE2, 8'h82);
    low_power <= 1'b1;
    @(posedge clk_sys);
    low_power <= 1'b0;
    expect_reg(`TRT_IDX_MODE2, 8'h80);
    expect_reg(`TRT_IDX_MODE1, 8'h83);
    // counter three on divided pulse edges; its underflow captures counter two
    bus_write(ba(`TRT_IDX_MODE2), 8'h00, r);
    k = 2 + $urandom % 6;
    bus_write(ba(`TRT_IDX_LOAD3), 8'(k), r);
    bus_write(ba(`TRT_IDX_IMASK), 8'h04, r);
    bus_read(ba(`TRT_IDX_ISTAT), d, r);
    trt_src_inst.dvc_pulses(1);
    @(posedge clk_sys);
    check({7'h0, irq}, 8'h1);
    expect_reg(`TRT_IDX_ISTAT, 8'h14);
    expect_reg(`TRT_IDX_CAP2, 8'h00);
    trt_src_inst.dvc_pulses(k);
    expect_reg(`TRT_IDX_ISTAT, 8'h00);
    trt_src_inst.dvc_pulses(1);
    expect_reg(`TRT_IDX_ISTAT, 8'h14);
    // counter two reloads on the pulse edge only while enabled
    d = 8'($urandom);
    bus_write(ba(`TRT_IDX_LOAD2), d, r);
    bus_write(ba(`TRT_IDX_MODE1), 8'h22, r);
    trt_src_inst.pulses(1);
    trt_src_inst.dvc_pulses(k + 1);
    expect_reg(`TRT_IDX_CAP2, d);
    bus_write(ba(`TRT_IDX_LOAD2), ~d, r);
    bus_write(ba(`TRT_IDX_MODE1), 8'h02, r);
    trt_src_inst.pulses(1);
    trt_src_inst.dvc_pulses(k + 1);
    expect_reg(`TRT_IDX_CAP2, d - 8'h01);
    conclude();
  end
endmodule // tb
`default_nettype wire
